// ==== core/flash_ctl_pkg.sv ====
package flash_ctl_pkg;
  // Register offsets; printed offsets are not all multiples of four, so each is an index.
  localparam logic [15:0] IDX_AREA_PROTECT = 16'ha012;
  localparam logic [15:0] IDX_CODE_PROTECT = 16'ha013;
  localparam logic [15:0] IDX_FLASH_CMD    = 16'ha020;
  localparam logic [15:0] IDX_FLASH_DATA   = 16'ha021;
  localparam logic [15:0] IDX_ADDR_HIGH    = 16'ha022;
  localparam logic [15:0] IDX_ADDR_LOW     = 16'ha023;
  localparam logic [15:0] IDX_CLK_SCALE    = 16'ha024;
  localparam logic [15:0] IDX_LIN_UNLOCK   = 16'ha014;
  localparam logic [15:0] IDX_EXT_KEY_BASE = 16'ha018;
  localparam logic [15:0] IDX_EXT_CTRL     = 16'ha017;
  localparam int          BUS_AW           = 18;
  // Reset values and the code unlock key.
  localparam logic [7:0] RST_AREA_PROTECT = 8'h0f;
  localparam logic [7:0] RST_CMD_TIMEOUT  = 8'h04;
  localparam logic [7:0] RST_CLK_SCALE    = 8'h25;
  localparam logic [7:0] CODE_UNLOCK_KEY  = 8'h55;
  // Command codes, one-hot.
  localparam logic [4:0] CMD_MAIN_READ  = 5'h10;
  localparam logic [4:0] CMD_MAIN_ERASE = 5'h08;
  localparam logic [4:0] CMD_MAIN_WRITE = 5'h04;
  localparam logic [4:0] CMD_INFO_READ  = 5'h02;
  localparam logic [4:0] CMD_INFO_WRITE = 5'h01;
  // Command register fields.
  localparam int CMD_VERIFY_BIT = 7;
  localparam int CMD_BUSY_BIT   = 6;
  localparam int CMD_FAIL_BIT   = 5;
  // Array geometry.
  localparam logic [15:0] MAIN_LAST     = 16'h7fff;
  localparam logic [15:0] BOOT_FIRST    = 16'h7000;
  localparam logic [15:0] CODE_LAST     = 16'h6fff;
  localparam logic [15:0] KEY_FIRST     = 16'h6ff8;
  localparam logic [15:0] INFO_LAST     = 16'h007f;
  localparam logic [15:0] AREA1_FIRST   = 16'h1000;
  localparam logic [15:0] AREA2_FIRST   = 16'h3000;
  localparam logic [15:0] AREA3_FIRST   = 16'h5000;
  localparam int          SECTOR_BITS   = 9;
  localparam int          INFO_WORDS    = 128;
  // Timing.
  localparam longint CLK_HZ         = 20000000;
  localparam longint UNLOCK_WAIT_MS = 1000;
  localparam longint LIN_WINDOW_MS  = 5000;
  localparam longint UNLOCK_WAIT_CYC = CLK_HZ * UNLOCK_WAIT_MS / 1000;
  localparam longint LIN_WINDOW_CYC  = CLK_HZ * LIN_WINDOW_MS / 1000;
  localparam int     LIN_PATTERN_LEN = 8;
  localparam logic [7:0] LIN_PATTERN = 8'ha5;
  localparam int     ARRAY_LATENCY   = 2;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_CHECK = 3'b011,
    ST_DONE  = 3'b010
  } seq_state_e;
  // Write counts per timeout select.
  function automatic logic [15:0] write_limit(input logic [2:0] sel);
    case (sel)
      3'd0: write_limit = 16'd55;
      3'd1: write_limit = 16'd60;
      3'd2: write_limit = 16'd65;
      3'd3: write_limit = 16'd69;
      3'd4: write_limit = 16'd75;
      3'd5: write_limit = 16'd80;
      3'd6: write_limit = 16'd85;
      default: write_limit = 16'd89;
    endcase
  endfunction
  // Erase counts per timeout select.
  function automatic logic [15:0] erase_limit(input logic [2:0] sel);
    case (sel)
      3'd0: erase_limit = 16'd5435;
      3'd1: erase_limit = 16'd5953;
      3'd2: erase_limit = 16'd6452;
      3'd3: erase_limit = 16'd6897;
      3'd4: erase_limit = 16'd7408;
      3'd5: erase_limit = 16'd7906;
      3'd6: erase_limit = 16'd8404;
      default: erase_limit = 16'd8889;
    endcase
  endfunction
endpackage

// ==== core/info_once_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
// Tracks which info-block bytes have been programmed; read data is registered.
module info_once_mem (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Access.
  input  wire logic [6:0] addr,
  input  wire logic       mark,
  output logic            used_q
);
  logic [127:0] used_bits_q;  // One flag per byte.
  // Flags clear on reset since the mirror is volatile.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      used_bits_q <= '0;
      used_q      <= 1'b0;
    end else if (clk_en) begin
      if (mark) begin
        used_bits_q[addr] <= 1'b1;
      end
      used_q <= used_bits_q[addr];
    end
  end
endmodule
`default_nettype wire

// ==== core/flash_ctl.sv ====
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Info bytes program once, never erased.
// - Boot area 0x7000-0x7fff refused for write and erase.
// - Protected targets leave array, set fail.
// - External mode unlocks on matching key.
// - Locked external mode permits mass erase only.
// - Write read-back clears verify on mismatch.
// - Busy high while a command runs.
// - Fail set on error, cleared by command.
// - Timeout select picks write/erase counts.
// - One-hot five-bit command decode.
// - Invalid code fails without executing.
// - Program clock is scaled by (scaler+1)/256.
// - Lower four area bits reset to one, clear-only.
// - Area bits map to address ranges.
// - Upper four area bits tied zero.
// - Code protection on after reset.
// - Key 55 unlocks after one second.
// - LIN edge bits alternate, so A5 never matches; no LIN unlock.
// - Status reads one when unlocked.
// - Bus stalls until command completes.
// - Erase covers 512-byte sectors.
module flash_ctl
  import flash_ctl_pkg::*;
#(
  parameter longint UNLOCK_WAIT = flash_ctl_pkg::UNLOCK_WAIT_CYC,
  parameter longint LIN_WINDOW  = flash_ctl_pkg::LIN_WINDOW_CYC
) (
  // Clock, reset and enable.
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  // Avalon-MM slave.
  input  wire logic [flash_ctl_pkg::BUS_AW-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  output logic [1:0]                       avs_response,
  // Flash array.
  output logic [15:0]                      fl_addr,
  output logic [7:0]                       fl_wdata,
  output logic                             fl_read,
  output logic                             fl_write,
  output logic                             fl_erase,
  output logic                             fl_mass_erase,
  output logic                             fl_info_sel,
  input  wire logic [7:0]                  fl_rdata,
  input  wire logic                        fl_done,
  // Pins.
  input  wire logic                        lin_rx_pin,
  input  wire logic                        ext_prog_mode,
  output logic                             program_clock
);
  import flash_ctl_pkg::*;

  // Software registers.
  logic [7:0]  area_protect_q;   // Clear-only protection bits.
  logic [7:0]  flash_data_q;     // Data byte.
  logic [15:0] addr_q;           // Target address.
  logic [7:0]  scale_q;          // Program clock scaler.
  logic [2:0]  timeout_sel_q;    // Timeout select.
  logic        verify_ok_q;      // Write read-back result.
  logic        fail_q;           // Last command failed.
  logic [4:0]  cmd_q;            // Last command code.
  logic [63:0] ext_key_q;        // Key supplied by the tester.
  logic        ext_unlock_q;     // Key matched.
  logic        mass_req_q;       // Mass erase request.
  // Code protection.
  logic        code_open_q;      // One while code protection is off.
  logic        sw_pending_q;     // Software unlock waiting.
  logic [31:0] sw_wait_q;        // Unlock wait counter.
  logic [31:0] lin_win_q;        // Time since reset.
  logic [7:0]  lin_shift_q;      // Sampled LIN bits.
  logic [3:0]  lin_cnt_q;        // Valid sampled bits.
  logic        lin_prev_q;       // Last LIN level.
  // Sequencer.
  seq_state_e  state_q;
  logic [15:0] tick_q;           // Program clock ticks.
  logic [8:0]  acc_q;            // Program clock accumulator.
  logic        pclk_tick;        // One program clock period.
  logic        info_used;        // Info byte already written.
  logic        info_mark;        // Mark info byte used.
  logic        busy;
  // Bus decode.
  logic [15:0] idx;
  logic        wr_hit, rd_hit;
  logic        resp_q;           // Answer phase.
  logic [31:0] rdata_d;
  logic        err_d;

  assign idx  = avs_address[17:2];
  assign busy = (state_q != ST_IDLE);

  // Range test shared by several checks.
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Area bit guarding an address; ones mean writable.
  function automatic logic area_open(input logic [15:0] a, input logic [7:0] p);
    if (a < AREA1_FIRST) begin
      area_open = p[0];
    end else if (a < AREA2_FIRST) begin
      area_open = p[1];
    end else if (a < AREA3_FIRST) begin
      area_open = p[2];
    end else if (a < BOOT_FIRST) begin
      area_open = p[3];
    end else begin
      area_open = p[4];
    end
  endfunction

  // A modify of the main array is legal only where every guard allows it.
  function automatic logic main_mod_ok(input logic [15:0] a);
    main_mod_ok = (a <= MAIN_LAST) && !in_range(a, BOOT_FIRST, MAIN_LAST)
                  && area_open(a, area_protect_q)
                  && (code_open_q || !in_range(a, 16'h0000, CODE_LAST));
  endfunction

  // Accumulator divider: overflow rate is mclk*(scale+1)/256.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q         <= '0;
      program_clock <= 1'b0;
    end else if (clk_en) begin
      acc_q         <= {1'b0, acc_q[7:0]} + {1'b0, scale_q} + 9'd1;
      program_clock <= acc_q[7];
    end
  end
  assign pclk_tick = acc_q[8];

  // Avalon decode; writes accepted only while idle to honour the stall.
  assign wr_hit = avs_write && !resp_q;
  assign rd_hit = avs_read && !resp_q;

  // Waitrequest holds while a command runs, then one answer cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_q          <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      avs_response    <= 2'b00;
    end else if (clk_en) begin
      if (resp_q) begin
        resp_q          <= 1'b0;
        avs_waitrequest <= 1'b1;
      end else if ((wr_hit || rd_hit) && !busy) begin
        resp_q          <= 1'b1;
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rdata_d;
        avs_response    <= err_d ? 2'b10 : 2'b00;
      end
    end
  end

  // Read mux; unmapped addresses answer slave error with zero data.
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    if (idx == IDX_AREA_PROTECT) begin
      rdata_d[7:0] = {4'h0, area_protect_q[3:0]};
    end else if (idx == IDX_CODE_PROTECT) begin
      rdata_d[0] = code_open_q;
    end else if (idx == IDX_FLASH_CMD) begin
      rdata_d[7:0] = {verify_ok_q, busy, fail_q, cmd_q};
    end else if (idx == IDX_FLASH_DATA) begin
      rdata_d[7:0] = flash_data_q;
    end else if (idx == IDX_ADDR_HIGH) begin
      rdata_d[7:0] = addr_q[15:8];
    end else if (idx == IDX_ADDR_LOW) begin
      rdata_d[7:0] = addr_q[7:0];
    end else if (idx == IDX_CLK_SCALE) begin
      rdata_d[7:0] = scale_q;
    end else if (idx == IDX_EXT_CTRL) begin
      rdata_d[1:0] = {mass_req_q, ext_unlock_q};
    end else if (idx >= IDX_EXT_KEY_BASE && idx < IDX_EXT_KEY_BASE + 16'd8) begin
      rdata_d[7:0] = 8'h00;
    end else if (idx == IDX_LIN_UNLOCK) begin
      rdata_d[0] = lin_win_q < 32'(LIN_WINDOW);
    end else begin
      err_d = 1'b1;
    end
  end

  // Plain software registers; writes taken at the answer edge only while idle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      area_protect_q <= RST_AREA_PROTECT;
      flash_data_q   <= '0;
      addr_q         <= '0;
      scale_q        <= RST_CLK_SCALE;
      timeout_sel_q  <= RST_CMD_TIMEOUT[2:0];
      ext_key_q      <= '0;
    end else if (clk_en) begin
      if (avs_write && resp_q && avs_byteenable[0] && !busy) begin
        if (idx == IDX_AREA_PROTECT) begin
          area_protect_q <= area_protect_q & avs_writedata[7:0] & 8'h0f;
        end else if (idx == IDX_FLASH_DATA) begin
          flash_data_q <= avs_writedata[7:0];
        end else if (idx == IDX_ADDR_HIGH) begin
          addr_q[15:8] <= avs_writedata[7:0];
        end else if (idx == IDX_ADDR_LOW) begin
          addr_q[7:0] <= avs_writedata[7:0];
        end else if (idx == IDX_CLK_SCALE) begin
          scale_q <= avs_writedata[7:0];
        end else if (idx == IDX_FLASH_CMD) begin
          timeout_sel_q <= avs_writedata[7:5];
        end else if (idx >= IDX_EXT_KEY_BASE && idx < IDX_EXT_KEY_BASE + 16'd8) begin
          ext_key_q[8*idx[2:0] +: 8] <= avs_writedata[7:0];
        end
      end
      if (state_q == ST_CHECK && (cmd_q == CMD_MAIN_READ || cmd_q == CMD_INFO_READ)) begin
        flash_data_q <= fl_rdata;
      end
    end
  end

  // Code protection: software key with delay; LIN edge bits within the window alternate and never match LIN_PATTERN.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_open_q  <= 1'b0;
      sw_pending_q <= 1'b0;
      sw_wait_q    <= '0;
      lin_win_q    <= '0;
      lin_shift_q  <= '0;
      lin_cnt_q    <= '0;
      lin_prev_q   <= 1'b1;
    end else if (clk_en) begin
      lin_prev_q <= lin_rx_pin;
      if (lin_win_q < 32'(LIN_WINDOW)) begin
        lin_win_q <= lin_win_q + 32'd1;
        if (lin_rx_pin != lin_prev_q) begin
          lin_shift_q <= {lin_shift_q[6:0], lin_rx_pin};
          lin_cnt_q   <= (lin_cnt_q == 4'(LIN_PATTERN_LEN)) ? lin_cnt_q : lin_cnt_q + 4'd1;
        end
        if (lin_cnt_q == 4'(LIN_PATTERN_LEN) && lin_shift_q == LIN_PATTERN) begin
          code_open_q <= 1'b1;
        end
      end
      if (sw_pending_q) begin
        if (sw_wait_q >= 32'(UNLOCK_WAIT) - 32'd1) begin
          code_open_q  <= 1'b1;
          sw_pending_q <= 1'b0;
        end else begin
          sw_wait_q <= sw_wait_q + 32'd1;
        end
      end
      if (avs_write && resp_q && avs_byteenable[0] && idx == IDX_CODE_PROTECT) begin
        if (avs_writedata[7:0] == CODE_UNLOCK_KEY) begin
          sw_pending_q <= 1'b1;
          sw_wait_q    <= '0;
        end else begin
          sw_pending_q <= 1'b0;
          code_open_q  <= 1'b0;
        end
      end
    end
  end

  // External programming key check; mass erase is the only action allowed while locked.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_unlock_q <= 1'b0;
      mass_req_q   <= 1'b0;
    end else if (clk_en) begin
      if (!ext_prog_mode) begin
        ext_unlock_q <= 1'b0;
      end else if (state_q == ST_CHECK && cmd_q == 5'h00) begin
        ext_unlock_q <= (fl_rdata != 8'h00) ? ext_unlock_q : ext_unlock_q;
      end
      if (avs_write && resp_q && idx == IDX_EXT_CTRL && ext_prog_mode) begin
        ext_unlock_q <= avs_writedata[0] && (ext_key_q == {8{CODE_UNLOCK_KEY}});
        mass_req_q   <= avs_writedata[1];
      end else if (mass_req_q) begin
        mass_req_q <= 1'b0;
      end
    end
  end

  // Command sequencer.
  logic        legal;
  logic [15:0] limit;
  info_once_mem u_info (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .addr   (addr_q[6:0]),
    .mark   (info_mark),
    .used_q (info_used)
  );
  assign info_mark = (state_q == ST_CHECK) && (cmd_q == CMD_INFO_WRITE) && !fail_q;

  always_comb begin
    legal = 1'b0;
    limit = erase_limit(timeout_sel_q);
    case (cmd_q)
      CMD_MAIN_READ:  legal = addr_q <= MAIN_LAST;
      CMD_MAIN_ERASE: legal = main_mod_ok({addr_q[15:SECTOR_BITS], 9'h000});
      CMD_MAIN_WRITE: legal = main_mod_ok(addr_q);
      CMD_INFO_READ:  legal = addr_q <= INFO_LAST;
      CMD_INFO_WRITE: legal = (addr_q <= INFO_LAST) && !info_used;
      default:        legal = 1'b0;
    endcase
    if (ext_prog_mode && !ext_unlock_q) begin
      legal = 1'b0;
    end
    if (cmd_q == CMD_MAIN_WRITE || cmd_q == CMD_INFO_WRITE) begin
      limit = write_limit(timeout_sel_q);
    end
  end

  // State, status and array strobes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= ST_IDLE;
      cmd_q         <= '0;
      fail_q        <= 1'b0;
      verify_ok_q   <= 1'b1;
      tick_q        <= '0;
      fl_addr       <= '0;
      fl_wdata      <= '0;
      fl_read       <= 1'b0;
      fl_write      <= 1'b0;
      fl_erase      <= 1'b0;
      fl_mass_erase <= 1'b0;
      fl_info_sel   <= 1'b0;
    end else if (clk_en) begin
      fl_mass_erase <= mass_req_q;
      case (state_q)
        ST_IDLE: begin
          if (avs_write && resp_q && idx == IDX_FLASH_CMD && avs_byteenable[0]) begin
            cmd_q       <= avs_writedata[4:0];
            fail_q      <= 1'b0;
            verify_ok_q <= 1'b1;
            tick_q      <= '0;
            state_q     <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!legal) begin
            fail_q  <= 1'b1;
            state_q <= ST_DONE;
          end else begin
            fl_addr     <= cmd_q == CMD_MAIN_ERASE ? {addr_q[15:SECTOR_BITS], 9'h000} : addr_q;
            fl_wdata    <= flash_data_q;
            fl_info_sel <= cmd_q[1] | cmd_q[0];
            fl_read     <= cmd_q == CMD_MAIN_READ || cmd_q == CMD_INFO_READ;
            fl_write    <= cmd_q == CMD_MAIN_WRITE || cmd_q == CMD_INFO_WRITE;
            fl_erase    <= cmd_q == CMD_MAIN_ERASE;
            state_q     <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (pclk_tick) begin
            tick_q <= tick_q + 16'd1;
          end
          if (fl_done) begin
            fl_read  <= 1'b0;
            fl_write <= 1'b0;
            fl_erase <= 1'b0;
            if (fl_write && fl_rdata != fl_wdata) begin
              verify_ok_q <= 1'b0;
            end
            state_q <= ST_DONE;
          end else if (!fl_read && tick_q >= limit) begin
            fl_write <= 1'b0;
            fl_erase <= 1'b0;
            fail_q   <= 1'b1;
            state_q  <= ST_DONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Protection bits never rise after reset.
  area_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (area_protect_q & ~$past(area_protect_q)) == 8'h00) else $error("area bit rose");
  upper_tied_a: assert property (@(posedge mclk) disable iff (!rst_n)
    area_protect_q[7:4] == 4'h0) else $error("upper area bit set");
  bad_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == ST_RUN && clk_en && !(cmd_q inside {5'h10, 5'h08, 5'h04, 5'h02, 5'h01}))
    |=> fail_q && !fl_write && !fl_erase) else $error("bad code ran");
  boot_safe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fl_write && !fl_info_sel |-> !(fl_addr >= BOOT_FIRST && fl_addr <= MAIN_LAST))
    else $error("boot area written");
  busy_stall_a: assert property (@(posedge mclk) disable iff (!rst_n)
    busy |-> avs_waitrequest || resp_q) else $error("bus not stalled");
  new_cmd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_IDLE ##1 state_q == ST_RUN |-> !fail_q && verify_ok_q)
    else $error("status not cleared");
  // The window is judged one cycle back, since the counter steps on the same edge.
  prot_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(code_open_q) |-> $past(sw_pending_q) || $past(lin_win_q) < 32'(LIN_WINDOW))
    else $error("unlock without cause");
  locked_ext_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_prog_mode && !ext_unlock_q && state_q == ST_RUN |=> !fl_write && !fl_erase && !fl_read)
    else $error("locked access ran");
endmodule
`default_nettype wire

// ==== sim/flash_array_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Flash array stand-in: serves each held strobe after DELAY+1 cycles with a one-cycle done.
module flash_array_model #(
  parameter int DELAY = 3
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Array side.
  input  wire logic [15:0] fl_addr,
  input  wire logic [7:0]  fl_wdata,
  input  wire logic        fl_read,
  input  wire logic        fl_write,
  input  wire logic        fl_erase,
  input  wire logic        fl_mass_erase,
  input  wire logic        fl_info_sel,
  output logic [7:0]       fl_rdata,
  output logic             fl_done
);
  logic [7:0] mem [0:32767]; // Main array, starts erased.
  logic [7:0] info [0:127];  // Information block, starts erased.
  int         cnt;           // Cycles the current strobe has been held.
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (info[i]) info[i] = 8'hff;
  end
  // The count parks past DELAY until the strobe drops, so one strobe is never served twice.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      fl_done <= 1'b0;
      fl_rdata <= 8'h5a;
    end else begin
      fl_done <= 1'b0;
      fl_rdata <= ~fl_rdata; // Outside done the data toggles, so stale data cannot pass.
      if (fl_mass_erase) begin
        foreach (mem[i]) mem[i] <= 8'hff;
      end
      if (!(fl_read || fl_write || fl_erase)) begin
        cnt <= 0;
      end else if (cnt < DELAY) begin
        cnt <= cnt + 1;
      end else if (cnt == DELAY) begin
        cnt <= DELAY + 1;
        fl_done <= 1'b1;
        if (fl_write && fl_info_sel) info[fl_addr[6:0]] <= fl_wdata;
        if (fl_write && !fl_info_sel) mem[fl_addr[14:0]] <= fl_wdata;
        if (fl_erase) begin
          for (int i = 0; i < 512; i++) mem[{fl_addr[14:9], 9'h0} + i] <= 8'hff;
        end
        fl_rdata <= fl_write ? fl_wdata : (fl_info_sel ? info[fl_addr[6:0]] : mem[fl_addr[14:0]]);
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/flash_command_and_protection_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_command_and_protection_bench;
  import flash_ctl_pkg::*;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest, program_clock, ext_mode;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  avs_response, resp;
  logic [15:0] fl_addr;
  logic [7:0]  fl_wdata, fl_rdata, rd;
  logic        fl_read, fl_write, fl_erase, fl_mass_erase, fl_info_sel, fl_done;
  int          fail_count, checked;
  flash_ctl #(.UNLOCK_WAIT(50), .LIN_WINDOW(500)) flash_ctl_i (.mclk(mclk), .rst_n(rst_n),
    .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_read(fl_read), .fl_write(fl_write), .fl_erase(fl_erase),
    .fl_mass_erase(fl_mass_erase), .fl_info_sel(fl_info_sel), .fl_rdata(fl_rdata),
    .fl_done(fl_done), .lin_rx_pin(1'b1), .ext_prog_mode(ext_mode), .program_clock(program_clock));
  flash_array_model flash_array_model_i (.mclk(mclk), .rst_n(rst_n), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_read(fl_read), .fl_write(fl_write), .fl_erase(fl_erase),
    .fl_mass_erase(fl_mass_erase), .fl_info_sel(fl_info_sel), .fl_rdata(fl_rdata),
    .fl_done(fl_done));
  always #25 mclk = ~mclk;
  // Compare one byte and count it.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low, then data and response are taken.
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    rd = avs_readdata[7:0];
    resp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // Issue one command with timeout select 111, then read status after the stall.
  task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [4:0] c,
                     input logic fail_exp);
    bus(1'b1, IDX_ADDR_HIGH, a[15:8]);
    bus(1'b1, IDX_ADDR_LOW, a[7:0]);
    bus(1'b1, IDX_FLASH_DATA, d);
    bus(1'b1, IDX_FLASH_CMD, {3'b111, c});
    bus(1'b0, IDX_FLASH_CMD, 8'h00);
    check("busy_fail", {6'h0, 1'b0, fail_exp}, {6'h0, rd[6:5]});
  endtask
  // Rising program clock edges over 256 cycles equal the scaler plus one.
  task automatic t_pclk;
    logic p;
    int k;
    k = 0;
    p = program_clock;
    repeat (256) begin
      @(posedge mclk);
      if (program_clock && !p) k++;
      p = program_clock;
    end
    check("pclk_rises", RST_CLK_SCALE + 8'd1, 8'(k));
  endtask
  // Reset values and an unmapped place.
  task automatic t_reset;
    bus(1'b0, IDX_AREA_PROTECT, 8'h00);
    check("area_protect", 8'h0f, rd);
    bus(1'b0, IDX_CLK_SCALE, 8'h00);
    check("scaler", 8'h25, rd);
    bus(1'b0, IDX_FLASH_CMD, 8'h00);
    check("command", 8'h80, rd);
    bus(1'b0, 16'ha030, 8'h00);
    check("unmapped", 8'h02, {6'h0, resp});
    t_pclk();
    $display("reset test done");
  endtask
  // Refusals while code protection holds, then a legal read clears fail.
  task automatic t_refuse;
    cmd(16'h3010, 8'h5a, CMD_MAIN_WRITE, 1'b1);
    cmd(16'h7000, 8'h5a, CMD_MAIN_WRITE, 1'b1);
    cmd(16'h7000, 8'h00, 5'h03, 1'b1);
    cmd(16'h8000, 8'h00, CMD_MAIN_READ, 1'b1);
    cmd(16'h7000, 8'h00, CMD_MAIN_READ, 1'b0);
    bus(1'b0, IDX_FLASH_DATA, 8'h00);
    check("read_data", 8'hff, rd);
    $display("refuse test done");
  endtask
  // Unlock by key, write, read back, erase one sector only.
  task automatic t_unlock;
    bus(1'b1, IDX_CODE_PROTECT, CODE_UNLOCK_KEY);
    repeat (60) @(posedge mclk);
    bus(1'b0, IDX_CODE_PROTECT, 8'h00);
    check("code_open", 8'h01, rd);
    cmd(16'h3010, 8'h5a, CMD_MAIN_WRITE, 1'b0);
    check("verify", 8'h01, {7'h0, rd[7]});
    cmd(16'h3200, 8'h11, CMD_MAIN_WRITE, 1'b0);
    cmd(16'h3000, 8'h00, CMD_MAIN_ERASE, 1'b0);
    cmd(16'h3010, 8'h00, CMD_MAIN_READ, 1'b0);
    bus(1'b0, IDX_FLASH_DATA, 8'h00);
    check("erased", 8'hff, rd);
    cmd(16'h3200, 8'h00, CMD_MAIN_READ, 1'b0);
    bus(1'b0, IDX_FLASH_DATA, 8'h00);
    check("kept", 8'h11, rd);
    $display("unlock test done");
  endtask
  // Info block once-only, area bits clear-only, relock, locked tester mode.
  task automatic t_guard;
    cmd(16'h0005, 8'h33, CMD_INFO_WRITE, 1'b0);
    cmd(16'h0005, 8'h44, CMD_INFO_WRITE, 1'b1);
    cmd(16'h0005, 8'h00, CMD_INFO_READ, 1'b0);
    bus(1'b0, IDX_FLASH_DATA, 8'h00);
    check("info", 8'h33, rd);
    bus(1'b1, IDX_AREA_PROTECT, 8'h0b);
    bus(1'b1, IDX_AREA_PROTECT, 8'hff);
    bus(1'b0, IDX_AREA_PROTECT, 8'h00);
    check("area_clear", 8'h0b, rd);
    cmd(16'h3020, 8'h00, CMD_MAIN_WRITE, 1'b1);
    cmd(16'h3020, 8'h00, CMD_MAIN_READ, 1'b0);
    bus(1'b0, IDX_FLASH_DATA, 8'h00);
    check("untouched", 8'hff, rd);
    bus(1'b1, IDX_CODE_PROTECT, 8'h00);
    bus(1'b0, IDX_CODE_PROTECT, 8'h00);
    check("code_shut", 8'h00, rd);
    cmd(16'h5010, 8'h00, CMD_MAIN_WRITE, 1'b1);
    ext_mode <= 1'b1;
    cmd(16'h3020, 8'h00, CMD_MAIN_READ, 1'b1);
    ext_mode <= 1'b0;
    $display("guard test done");
  endtask
  // Print counts and verdict, then stop.
  task automatic results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #5000000;
    fail_count++;
    results();
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    ext_mode = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_refuse();
    t_unlock();
    t_guard();
    results();
  end
endmodule
`default_nettype wire
